/* File: design/esalm_err_class.sv */
// error number range classifier
// assumes a binary error number, combinational use
`timescale 1ns/100ps
`include "esalm_cfg.svh"
module esalm_err_class (
	input wire logic [15:0] err_num,
	output esalm_pkg::esalm_class_e err_class
);
	always_comb begin
		if (err_num < `ESALM_SYS_FIRST) begin
			err_class = esalm_pkg::ESALM_CL_NONE;
		end else if (err_num < `ESALM_DIAG_FIRST) begin
			err_class = esalm_pkg::ESALM_CL_SYSTEM; // (R11)
		end else if (err_num < `ESALM_GEN_FIRST) begin
			err_class = esalm_pkg::ESALM_CL_DIAG; // (R11)
		end else if (err_num < `ESALM_AXIS_FIRST) begin
			err_class = esalm_pkg::ESALM_CL_GENERAL; // (R11)
		end else if (err_num <= `ESALM_AXIS_LAST) begin
			err_class = esalm_pkg::ESALM_CL_AXIS; // (R11)
		end else begin
			err_class = esalm_pkg::ESALM_CL_NONE;
		end
	end
endmodule

/* File: design/esalm_life_mon.sv */
// sign-of-life watchdog on the host's life counter
// assumes life_cnt is a register of the same clock domain
`timescale 1ns/100ps
`include "esalm_cfg.svh"
module esalm_life_mon #(
	parameter int CNT_W = 34,
	parameter longint RUN_CYC = `ESALM_RUN_TIMEOUT_CYC,
	parameter longint START_CYC = `ESALM_START_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] life_cnt,
	input wire logic restart,
	output logic alive_seen,
	output logic run_timeout,
	output logic start_timeout
);
	localparam logic [CNT_W-1:0] RUN_LIM = CNT_W'(RUN_CYC - 1);
	localparam logic [CNT_W-1:0] START_LIM = CNT_W'(START_CYC - 1);

	if (RUN_CYC < 2 || START_CYC < 2 || START_CYC > (64'd1 << CNT_W))
	begin : g_chk
		$error("esalm_life_mon: timeout counts do not fit");
	end

	esalm_pkg::esalm_life_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [15:0] prev_q, prev_d;
	logic seen_q, seen_d;
	logic run_to_d, start_to_d, run_to_q, start_to_q;
	logic change;

	assign change = life_cnt != prev_q; // (R14)

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + CNT_W'(1);
		prev_d = life_cnt; // (R14)
		seen_d = seen_q;
		run_to_d = 1'b0;
		start_to_d = 1'b0;
		case (state_q)
			esalm_pkg::ESALM_LM_START: begin
				if (change) begin
					state_d = esalm_pkg::ESALM_LM_RUN;
					cnt_d = '0;
					seen_d = 1'b1;
				end else if (cnt_q == START_LIM) begin
					state_d = esalm_pkg::ESALM_LM_FAULT; // (R15)
					start_to_d = 1'b1; // (R15)
				end
			end
			esalm_pkg::ESALM_LM_RUN: begin
				if (change) begin
					cnt_d = '0; // (R14)
				end else if (cnt_q == RUN_LIM) begin
					state_d = esalm_pkg::ESALM_LM_FAULT; // (R12)
					run_to_d = 1'b1; // (R12)
				end
			end
			esalm_pkg::ESALM_LM_FAULT: begin
				cnt_d = '0;
			end
			default: begin
				state_d = esalm_pkg::ESALM_LM_START;
				cnt_d = '0;
			end
		endcase
		if (restart) begin
			state_d = esalm_pkg::ESALM_LM_START; // (R12)
			cnt_d = '0;
			seen_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= esalm_pkg::ESALM_LM_START;
			cnt_q <= '0;
			prev_q <= 16'h0000;
			seen_q <= 1'b0;
			run_to_q <= 1'b0;
			start_to_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			prev_q <= prev_d;
			seen_q <= seen_d;
			run_to_q <= run_to_d;
			start_to_q <= start_to_d;
		end
	end

	assign alive_seen = seen_q;
	assign run_timeout = run_to_q;
	assign start_timeout = start_to_q;
endmodule

/* File: design/esalm_top.sv */
// error status and sign-of-life monitor with APB register access
// assumes APB master on pclk; error sources synchronous to pclk
//
// Functional notes
// (R01) controller ready drops on system, LED-shown or readiness-removing errors
// (R02) ready returns only after cause gone plus cold restart, or reset
// (R03) error-with-stop set for errors that stop machining and block start
// (R04) host reset request acknowledges and clears error-with-stop
// (R05) error-without-stop set for warning-only errors
// (R06) warning flag cleared by cancel request, panel cancel or reset request
// (R07) system ready low on comm fault, incomplete power-up or diag alarm
// (R08) losing system ready writes responsible number into basic error word
// (R09) axis positioning error number kept in its own byte
// (R10) error active while a numbered error pends; number stays readable
// (R11) error numbers classified into system, diag, general and axis ranges
// (R12) no life change in 100 ms: error 2000, not ready, stop, cold restart
// (R13) host increments life counter once every 10 ms
// (R14) any life counter change since last sample is a sign of life
// (R15) no sign of life 50 s after power-up: error 2001, ready withheld
// (R16) error flags stay latched until their acknowledge or restart
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "esalm_cfg.svh"
module esalm_top #(
	parameter int CNT_W = 34,
	parameter longint RUN_CYC = `ESALM_RUN_TIMEOUT_CYC,
	parameter longint START_CYC = `ESALM_START_TIMEOUT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic err_valid,
	input wire logic [15:0] err_num,
	input wire logic err_no_ready,
	input wire logic err_stop,
	input wire logic err_warning,
	input wire logic sys_error,
	input wire logic led_error,
	input wire logic comm_fault,
	input wire logic diag_alarm,
	input wire logic power_up_done,
	input wire logic panel_cancel,
	input wire logic axis_err_valid,
	input wire logic [7:0] axis_err_num,
	output logic controller_ready,
	output logic system_ready,
	output logic error_active,
	output logic error_with_stop,
	output logic error_without_stop,
	output logic start_disable,
	output logic machining_stop,
	output logic irq
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = a[7:2] == o[7:2];
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, `ESALM_OFF_CTRL) || hit(a, `ESALM_OFF_LIFE) ||
			hit(a, `ESALM_OFF_STAT) || hit(a, `ESALM_OFF_GFERR) ||
			hit(a, `ESALM_OFF_AXERR) || hit(a, `ESALM_OFF_ERRNUM) ||
			hit(a, `ESALM_OFF_IRQST) || hit(a, `ESALM_OFF_IRQMSK);
	endfunction

	logic wr, setup_rd;
	logic reset_req, cold_restart, cancel_req;
	logic alive_seen, run_to, start_to;
	esalm_pkg::esalm_class_e cls;

	logic [15:0] life_q, life_d;
	logic ready_lost_q, ready_lost_d;
	logic ctrl_rdy_q, ctrl_rdy_d;
	logic stop_q, stop_d;
	logic warn_q, warn_d;
	logic life_err_q, life_err_d;
	logic sys_rdy_q, sys_rdy_d;
	logic [15:0] gf_err_q, gf_err_d;
	logic [15:0] err_num_q, err_num_d;
	logic [15:0] life_code_q, life_code_d;
	esalm_pkg::esalm_class_e cls_q, cls_d;
	logic [7:0] axis_q, axis_d;
	logic axis_err_q, axis_err_d;
	logic [`ESALM_IRQ_W-1:0] irq_st_q, irq_st_d;
	logic [`ESALM_IRQ_W-1:0] irq_mk_q, irq_mk_d;
	logic [`ESALM_IRQ_W-1:0] irq_ev;
	logic [31:0] rd_q, rd_d;
	logic err_q, err_d;
	logic pend_q, pend_d;
	logic irq_q, irq_d;

	esalm_err_class u_class (
		.err_num(err_num),
		.err_class(cls)
	);

	esalm_life_mon #(
		.CNT_W(CNT_W),
		.RUN_CYC(RUN_CYC),
		.START_CYC(START_CYC)
	) u_life (
		.clk(pclk),
		.rst_n(presetn),
		.life_cnt(life_q),
		.restart(cold_restart),
		.alive_seen(alive_seen),
		.run_timeout(run_to),
		.start_timeout(start_to)
	);

	// apb decode, writes land at the access edge
	assign wr = psel && penable && pwrite && mapped(paddr);
	assign setup_rd = psel && !penable;
	assign reset_req = wr && hit(paddr, `ESALM_OFF_CTRL) &&
		pwdata[`ESALM_CTRL_RESET_REQ];
	assign cold_restart = wr && hit(paddr, `ESALM_OFF_CTRL) &&
		pwdata[`ESALM_CTRL_COLD_RESTART];
	assign cancel_req = wr && hit(paddr, `ESALM_OFF_CTRL) &&
		pwdata[`ESALM_CTRL_CANCEL];

	// error state
	always_comb begin
		life_d = life_q;
		if (wr && hit(paddr, `ESALM_OFF_LIFE)) begin
			life_d = pwdata[15:0]; // (R13)
		end
		life_err_d = life_err_q;
		if (cold_restart) begin
			life_err_d = 1'b0; // (R12)
		end
		if (run_to || start_to) begin
			life_err_d = 1'b1; // (R12) (R15)
		end
		life_code_d = life_code_q;
		if (run_to) begin
			life_code_d = `ESALM_ERR_LIFE_RUN; // (R12)
		end else if (start_to) begin
			life_code_d = `ESALM_ERR_LIFE_START; // (R15)
		end
		ready_lost_d = ready_lost_q;
		if (cold_restart && !sys_error && !led_error) begin
			ready_lost_d = 1'b0; // (R02)
		end
		if (sys_error || led_error || run_to || start_to ||
			(err_valid && (err_no_ready ||
			cls == esalm_pkg::ESALM_CL_SYSTEM))) begin
			ready_lost_d = 1'b1; // (R01) (R16)
		end
		ctrl_rdy_d = !ready_lost_d && !life_err_d && alive_seen; // (R15)
		stop_d = stop_q;
		if (reset_req) begin
			stop_d = 1'b0; // (R04)
		end
		if (err_valid && err_stop) begin
			stop_d = 1'b1; // (R03) (R16)
		end
		warn_d = warn_q;
		if (reset_req || cancel_req || panel_cancel) begin
			warn_d = 1'b0; // (R06)
		end
		if (err_valid && err_warning) begin
			warn_d = 1'b1; // (R05) (R16)
		end
		sys_rdy_d = power_up_done && !comm_fault && !diag_alarm &&
			!life_err_d; // (R07)
		pend_d = pend_q && !(reset_req || cancel_req || panel_cancel ||
			cold_restart); // (R10)
		err_num_d = err_num_q;
		cls_d = cls_q;
		if (err_valid) begin
			err_num_d = err_num; // (R10)
			pend_d = 1'b1; // (R10) (R16)
			cls_d = cls; // (R11)
		end
		if (run_to) begin
			err_num_d = `ESALM_ERR_LIFE_RUN; // (R12)
			cls_d = esalm_pkg::ESALM_CL_DIAG;
		end else if (start_to) begin
			err_num_d = `ESALM_ERR_LIFE_START; // (R15)
			cls_d = esalm_pkg::ESALM_CL_DIAG;
		end
		gf_err_d = gf_err_q;
		if (sys_rdy_q && !sys_rdy_d) begin
			gf_err_d = life_err_d ? life_code_d : err_num_d; // (R08)
		end
		axis_d = axis_q;
		axis_err_d = axis_err_q;
		if (reset_req) begin
			axis_err_d = 1'b0;
		end
		if (axis_err_valid) begin
			axis_d = axis_err_num; // (R09)
			axis_err_d = 1'b1;
		end
		err_d = ready_lost_d || stop_d || warn_d || life_err_d ||
			pend_d; // (R10)
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			life_q <= 16'h0000;
			life_err_q <= 1'b0;
			life_code_q <= 16'h0000;
			ready_lost_q <= 1'b0;
			ctrl_rdy_q <= 1'b0;
			stop_q <= 1'b0;
			warn_q <= 1'b0;
			sys_rdy_q <= 1'b0;
			err_num_q <= 16'h0000;
			cls_q <= esalm_pkg::ESALM_CL_NONE;
			gf_err_q <= 16'h0000;
			axis_q <= 8'h00;
			axis_err_q <= 1'b0;
			err_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			life_q <= life_d;
			life_err_q <= life_err_d;
			life_code_q <= life_code_d;
			ready_lost_q <= ready_lost_d;
			ctrl_rdy_q <= ctrl_rdy_d;
			stop_q <= stop_d;
			warn_q <= warn_d;
			sys_rdy_q <= sys_rdy_d;
			err_num_q <= err_num_d;
			cls_q <= cls_d;
			gf_err_q <= gf_err_d;
			axis_q <= axis_d;
			axis_err_q <= axis_err_d;
			err_q <= err_d;
			pend_q <= pend_d;
		end
	end

	// interrupt status, set wins over write-one-to-clear
	assign irq_ev[`ESALM_IRQ_READY_LOST] = ctrl_rdy_q && !ctrl_rdy_d;
	assign irq_ev[`ESALM_IRQ_ERR_STOP] = !stop_q && stop_d;
	assign irq_ev[`ESALM_IRQ_ERR_WARN] = !warn_q && warn_d;
	assign irq_ev[`ESALM_IRQ_LIFE] = run_to || start_to;

	always_comb begin
		irq_st_d = irq_st_q;
		irq_mk_d = irq_mk_q;
		if (wr && hit(paddr, `ESALM_OFF_IRQST)) begin
			irq_st_d = irq_st_q & ~pwdata[`ESALM_IRQ_W-1:0];
		end
		if (wr && hit(paddr, `ESALM_OFF_IRQMSK)) begin
			irq_mk_d = pwdata[`ESALM_IRQ_W-1:0];
		end
		irq_st_d = irq_st_d | irq_ev;
		irq_d = |(irq_st_d & irq_mk_d);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_q <= '0;
			irq_mk_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			irq_mk_q <= irq_mk_d;
			irq_q <= irq_d;
		end
	end

	// read data captured in the setup cycle
	always_comb begin
		rd_d = rd_q;
		if (setup_rd) begin
			rd_d = 32'h0000_0000;
			if (hit(paddr, `ESALM_OFF_LIFE)) begin
				rd_d[15:0] = life_q;
			end else if (hit(paddr, `ESALM_OFF_STAT)) begin
				rd_d[`ESALM_ST_CTRL_READY] = ctrl_rdy_q;
				rd_d[`ESALM_ST_SYS_READY] = sys_rdy_q;
				rd_d[`ESALM_ST_ERR_ACTIVE] = err_q;
				rd_d[`ESALM_ST_ERR_STOP] = stop_q;
				rd_d[`ESALM_ST_ERR_WARN] = warn_q;
				rd_d[`ESALM_ST_LIFE_ERR] = life_err_q;
				rd_d[`ESALM_ST_AXIS_ERR] = axis_err_q;
				rd_d[`ESALM_ST_CLASS_LSB +: 3] = cls_q;
			end else if (hit(paddr, `ESALM_OFF_GFERR)) begin
				rd_d[15:0] = gf_err_q; // (R08)
			end else if (hit(paddr, `ESALM_OFF_AXERR)) begin
				rd_d[7:0] = axis_q; // (R09)
			end else if (hit(paddr, `ESALM_OFF_ERRNUM)) begin
				rd_d[15:0] = err_num_q; // (R10)
			end else if (hit(paddr, `ESALM_OFF_IRQST)) begin
				rd_d[`ESALM_IRQ_W-1:0] = irq_st_q;
			end else if (hit(paddr, `ESALM_OFF_IRQMSK)) begin
				rd_d[`ESALM_IRQ_W-1:0] = irq_mk_q;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q <= 32'h0000_0000;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign prdata = rd_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign controller_ready = ctrl_rdy_q;
	assign system_ready = sys_rdy_q;
	assign error_active = err_q;
	assign error_with_stop = stop_q;
	assign error_without_stop = warn_q;
	assign start_disable = stop_q || life_err_q; // (R12)
	assign machining_stop = stop_q || life_err_q; // (R12)
	assign irq = irq_q;
endmodule

/* File: include/esalm_cfg.svh */
// register offsets, field positions and timing figures of the error monitor
// assumes a 250 MHz APB clock and 32-bit APB data
`ifndef ESALM_CFG_SVH
`define ESALM_CFG_SVH

`define ESALM_OFF_CTRL 8'h00
`define ESALM_OFF_LIFE 8'h04
`define ESALM_OFF_STAT 8'h08
`define ESALM_OFF_GFERR 8'h0c
`define ESALM_OFF_AXERR 8'h10
`define ESALM_OFF_ERRNUM 8'h14
`define ESALM_OFF_IRQST 8'h18
`define ESALM_OFF_IRQMSK 8'h1c

`define ESALM_CTRL_RESET_REQ 0
`define ESALM_CTRL_COLD_RESTART 1
`define ESALM_CTRL_CANCEL 2

`define ESALM_ST_CTRL_READY 0
`define ESALM_ST_SYS_READY 1
`define ESALM_ST_ERR_ACTIVE 2
`define ESALM_ST_ERR_STOP 3
`define ESALM_ST_ERR_WARN 4
`define ESALM_ST_LIFE_ERR 5
`define ESALM_ST_AXIS_ERR 6
`define ESALM_ST_CLASS_LSB 8

`define ESALM_IRQ_READY_LOST 0
`define ESALM_IRQ_ERR_STOP 1
`define ESALM_IRQ_ERR_WARN 2
`define ESALM_IRQ_LIFE 3
`define ESALM_IRQ_W 4

`define ESALM_CLK_MHZ 250
`define ESALM_RUN_TIMEOUT_MS 100
`define ESALM_START_TIMEOUT_S 50
`define ESALM_RUN_TIMEOUT_CYC \
	(64'd`ESALM_RUN_TIMEOUT_MS * 64'd1000 * 64'd`ESALM_CLK_MHZ)
`define ESALM_START_TIMEOUT_CYC \
	(64'd`ESALM_START_TIMEOUT_S * 64'd1000000 * 64'd`ESALM_CLK_MHZ)

`define ESALM_ERR_LIFE_RUN 16'h07d0
`define ESALM_ERR_LIFE_START 16'h07d1
`define ESALM_SYS_FIRST 16'h03e8
`define ESALM_DIAG_FIRST 16'h07d0
`define ESALM_GEN_FIRST 16'h2710
`define ESALM_AXIS_FIRST 16'h4e20
`define ESALM_AXIS_LAST 16'h752f

`endif

/* File: include/esalm_pkg.sv */
// types shared by the error monitor modules
// assumes nothing beyond the tool's SystemVerilog support
package esalm_pkg;
	typedef enum logic [2:0] {
		ESALM_LM_START = 3'b001,
		ESALM_LM_RUN = 3'b010,
		ESALM_LM_FAULT = 3'b100
	} esalm_life_e;

	typedef enum logic [2:0] {
		ESALM_CL_NONE = 3'h0,
		ESALM_CL_SYSTEM = 3'h1,
		ESALM_CL_DIAG = 3'h2,
		ESALM_CL_GENERAL = 3'h3,
		ESALM_CL_AXIS = 3'h4
	} esalm_class_e;
endpackage

/* File: testbench/esalm_checker.sv */
// port assertions for the error status and life monitor
// assumes one pclk domain, bound into esalm_top
`timescale 1ns/100ps
module esalm_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic err_valid,
	input wire logic err_stop,
	input wire logic err_warning,
	input wire logic sys_error,
	input wire logic led_error,
	input wire logic comm_fault,
	input wire logic diag_alarm,
	input wire logic power_up_done,
	input wire logic panel_cancel,
	input wire logic controller_ready,
	input wire logic system_ready,
	input wire logic error_active,
	input wire logic error_with_stop,
	input wire logic error_without_stop,
	input wire logic start_disable,
	input wire logic machining_stop
);
	logic ctl;
	logic rq;
	logic cq;
	assign ctl = psel && penable && pwrite && paddr[7:2] == 6'h00;
	assign rq = ctl && pwdata[0];
	assign cq = panel_cancel || rq || (ctl && pwdata[2]);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	rdy_drop_a: assert property ((sys_error || led_error)
		|=> !controller_ready)
		else $error("ready kept under system error");
	stop_set_a: assert property (err_valid && err_stop |=>
		error_with_stop && start_disable && machining_stop)
		else $error("stop error not flagged");
	stop_ack_a: assert property (rq && !(err_valid && err_stop)
		|=> !error_with_stop)
		else $error("stop flag kept after reset request");
	stop_hold_a: assert property (error_with_stop && !rq
		|=> error_with_stop)
		else $error("stop flag lost without acknowledge");
	warn_set_a: assert property (err_valid && err_warning
		|=> error_without_stop)
		else $error("warning not flagged");
	warn_clr_a: assert property (cq && !(err_valid && err_warning)
		|=> !error_without_stop)
		else $error("warning kept after cancel");
	warn_hold_a: assert property (error_without_stop && !cq
		|=> error_without_stop)
		else $error("warning lost without acknowledge");
	sys_low_a: assert property ((comm_fault || diag_alarm || !power_up_done)
		|=> !system_ready)
		else $error("system ready kept under fault");
	act_set_a: assert property (err_valid |=> error_active)
		else $error("error active not set");
endmodule

bind esalm_top esalm_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .err_valid(err_valid), .err_stop(err_stop),
	.err_warning(err_warning), .sys_error(sys_error), .led_error(led_error),
	.comm_fault(comm_fault), .diag_alarm(diag_alarm),
	.power_up_done(power_up_done), .panel_cancel(panel_cancel),
	.controller_ready(controller_ready), .system_ready(system_ready),
	.error_active(error_active), .error_with_stop(error_with_stop),
	.error_without_stop(error_without_stop),
	.start_disable(start_disable), .machining_stop(machining_stop));

/* File: testbench/esalm_host_model.sv */
// host cpu model: life count stepped once per period
// assumes the bench copies life_cnt into the life register
`timescale 1ns/100ps
module esalm_host_model #(
	parameter int PER = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic [15:0] life_cnt
);
	int cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			life_cnt <= 16'h0000;
		end else if (run) begin
			if (cnt == PER - 1) begin
				cnt <= 0;
				life_cnt <= life_cnt + 16'h0001;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the error status and life monitor
// assumes short timeouts: run 50, startup 200 cycles
`timescale 1ns/100ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, an = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [15:0] en = 16'h0000, life;
	logic ev = 1'b0, nr = 1'b0, st = 1'b0, wn = 1'b0, se = 1'b0, le = 1'b0;
	logic cf = 1'b0, da = 1'b0, pu = 1'b1, pc = 1'b0, av = 1'b0, hrun = 1'b0;
	logic pready, pslverr, rdy, srdy, act, stp, wrn, sdis, mstp, irq, e;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	esalm_top #(.RUN_CYC(50), .START_CYC(200)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .err_valid(ev), .err_num(en), .err_no_ready(nr),
		.err_stop(st), .err_warning(wn), .sys_error(se), .led_error(le),
		.comm_fault(cf), .diag_alarm(da), .power_up_done(pu),
		.panel_cancel(pc), .axis_err_valid(av), .axis_err_num(an),
		.controller_ready(rdy), .system_ready(srdy), .error_active(act),
		.error_with_stop(stp), .error_without_stop(wrn),
		.start_disable(sdis), .machining_stop(mstp), .irq(irq));
	esalm_host_model #(.PER(10)) host (.clk(pclk), .rst_n(presetn),
		.run(hrun), .life_cnt(life));
	initial forever #2 pclk = ~pclk;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), x, q & m);
	endtask
	task automatic nd();
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic live(input int n);
		repeat (n) apb(1'b1, 8'h04, {16'h0000, life});
	endtask
	task automatic err(input logic [15:0] n, input logic s, input logic w);
		@(posedge pclk);
		ev <= 1'b1;
		en <= n;
		st <= s;
		wn <= w;
		@(posedge pclk);
		ev <= 1'b0;
	endtask
	task automatic t_life();
		nd();
		chk("ready", 0, rdy);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped rd", 32'h0, q);
		chk("unmapped err", 32'h1, {31'h0, e});
		rc(8'h1c, 32'hf, 32'h0);
		hrun <= 1'b1;
		live(8);
		nd();
		chk("ready", 1, rdy);
		chk("sys ready", 1, srdy);
		hrun <= 1'b0;
		repeat (60) @(posedge pclk);
		nd();
		chk("ready", 0, rdy);
		chk("mstp", 1, mstp);
		chk("sdis", 1, sdis);
		rc(8'h0c, 32'hffff, 32'h07d0);
		rc(8'h18, 32'h8, 32'h8);
		hrun <= 1'b1;
		live(8);
		nd();
		chk("ready", 0, rdy);
		apb(1'b1, 8'h00, 32'h2);
		live(8);
		nd();
		chk("ready", 1, rdy);
		chk("sdis", 0, sdis);
		@(posedge pclk);
		hrun <= 1'b0;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (220) @(posedge pclk);
		nd();
		chk("ready", 0, rdy);
		rc(8'h0c, 32'hffff, 32'h07d1);
		hrun <= 1'b1;
		apb(1'b1, 8'h00, 32'h2);
		live(8);
		nd();
		chk("ready", 1, rdy);
	endtask
	task automatic t_err();
		logic [15:0] nums [4];
		nums = '{16'h07cf, 16'h270f, 16'h2710, 16'h752f};
		apb(1'b1, 8'h18, 32'hf);
		apb(1'b1, 8'h1c, 32'h2);
		err(16'h4e25, 1'b1, 1'b0);
		nd();
		chk("stop", 1, stp);
		chk("act", 1, act);
		chk("irq", 1, irq);
		rc(8'h14, 32'hffff, 32'h4e25);
		apb(1'b1, 8'h1c, 32'h0);
		nd();
		chk("irq", 0, irq);
		apb(1'b1, 8'h00, 32'h1);
		nd();
		chk("stop", 0, stp);
		for (int k = 0; k < 3; k++) begin
			err(16'h0834, 1'b0, 1'b1);
			rc(8'h08, 32'h710, 32'h210);
			if (k == 0)
				apb(1'b1, 8'h00, 32'h4);
			else if (k == 1) begin
				@(posedge pclk);
				pc <= 1'b1;
				@(posedge pclk);
				pc <= 1'b0;
			end else
				apb(1'b1, 8'h00, 32'h1);
			nd();
			chk("warn", 0, wrn);
		end
		for (int k = 0; k < 4; k++) begin
			err(nums[k], 1'b0, 1'b0);
			rc(8'h08, 32'h700, (k + 1) << 8);
		end
		nd();
		chk("ready", 0, rdy);
	endtask
	task automatic t_sys();
		@(posedge pclk);
		se <= 1'b1;
		apb(1'b1, 8'h00, 32'h2);
		live(8);
		nd();
		chk("ready", 0, rdy);
		@(posedge pclk);
		se <= 1'b0;
		le <= 1'b1;
		apb(1'b1, 8'h00, 32'h2);
		live(8);
		nd();
		chk("ready", 0, rdy);
		@(posedge pclk);
		le <= 1'b0;
		apb(1'b1, 8'h00, 32'h2);
		live(8);
		nd();
		chk("ready", 1, rdy);
		@(posedge pclk);
		nr <= 1'b1;
		err(16'h2711, 1'b0, 1'b0);
		nr <= 1'b0;
		cf <= 1'b1;
		nd();
		chk("sys ready", 0, srdy);
		chk("ready", 0, rdy);
		rc(8'h0c, 32'hffff, 32'h2711);
		@(posedge pclk);
		cf <= 1'b0;
		da <= 1'b1;
		av <= 1'b1;
		an <= 8'h5a;
		@(posedge pclk);
		av <= 1'b0;
		rc(8'h10, 32'hff, 32'h5a);
		rc(8'h08, 32'h42, 32'h40);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_life();
		t_err();
		t_sys();
		end_sim();
	end
endmodule
